// file: logic/cfl_pkg.sv
// cfl_pkg: register offsets, field positions, reset values and carrier types for the critical-fault log trigger
// assumes one clock domain and a byte-wide register port driven by the configuration interface logic
`default_nettype none

package cfl_pkg;

   localparam int unsigned NUM_CH = 12;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RES_W = 8;

   // register byte addresses
   localparam logic [7:0] ADDR_LOG_CONTENT = 8'h47;
   localparam logic [7:0] ADDR_UV_EN_LOW = 8'h48;
   localparam logic [7:0] ADDR_UVOV_EN_MIXED = 8'h49;
   localparam logic [7:0] ADDR_OV_EN_HIGH = 8'h4a;

   // reset values
   localparam logic [7:0] RST_LOG_CONTENT = 8'h00;
   localparam logic [7:0] RST_UV_EN_LOW = 8'h00;
   localparam logic [7:0] RST_UVOV_EN_MIXED = 8'h00;
   localparam logic [7:0] RST_OV_EN_HIGH = 8'h00;

   // field positions
   localparam int unsigned CONTENT_LSB = 0;
   localparam int unsigned CONTENT_W = 2;
   localparam int unsigned MIXED_UV_LSB = 0;
   localparam int unsigned MIXED_UV_W = 4;
   localparam int unsigned MIXED_OV_LSB = 4;
   localparam int unsigned MIXED_OV_W = 4;
   localparam int unsigned HIGH_OV_LSB = 0;
   localparam int unsigned HIGH_OV_W = 8;
   localparam int unsigned LOW_UV_W = 8;
   localparam int unsigned SMALL_CH = 8;

   // log content encodings
   typedef enum logic [1:0] {
      CFL_SAVE_BOTH = 2'h0,
      CFL_SAVE_FLAGS = 2'h1,
      CFL_SAVE_VALUES = 2'h2,
      CFL_SAVE_NONE = 2'h3
   } cfl_content_t;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cfl_reg_req_t;

   // per-channel comparator results from the deglitched monitor
   typedef struct packed {
      logic [NUM_CH-1:0] uv;
      logic [NUM_CH-1:0] ov;
   } cfl_cmp_t;

   // command handed to the nonvolatile log writer
   typedef struct packed {
      logic store_flags;
      logic store_values;
      logic [NUM_CH-1:0] fail_flags;
      logic [NUM_CH*RES_W-1:0] values;
   } cfl_log_cmd_t;

endpackage : cfl_pkg

`default_nettype wire

// file: logic/cfl_chan_arm.sv
// cfl_chan_arm: one monitored channel's arming and readable fault flag
// assumes comparator pulses are already deglitched and on mclk
`default_nettype none

module cfl_chan_arm (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // configuration
   input wire logic uv_en,
   input wire logic ov_en,
   input wire logic present,
   // comparator results
   input wire logic uv_hit,
   input wire logic ov_hit,
   // flag clear (write one)
   input wire logic flag_clr,
   // results
   output logic armed_hit,
   output logic flag_r
);

   logic flag_nxt;

   // a comparison counts only while its enable is set and the channel exists
   assign armed_hit = present & ((uv_en & uv_hit) | (ov_en & ov_hit)); // RULE_05 RULE_12 RULE_14

   // set wins over a clear in the same cycle
   always_comb begin
      flag_nxt = flag_r;
      if (flag_clr) begin
         flag_nxt = 1'b0;
      end
      if (armed_hit) begin
         flag_nxt = 1'b1; // RULE_12
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

endmodule : cfl_chan_arm

`default_nettype wire

// file: logic/cfl_trigger.sv
// cfl_trigger: log-content select, per-channel critical enables, fault trigger, shutdown and log lock
// assumes a byte register port on mclk, deglitched comparator results on mclk, and a log writer that
// answers each log request with a done pulse; the small variant is chosen by the small_variant input
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// RULE_01: content 00 stores flags and conversion values
// RULE_02: content 01 stores failure flags only
// RULE_03: content 10 stores conversion values only
// RULE_04: content 11 stores nothing, logger off
// RULE_05: first enable bits arm channels 1-8 undervoltage
// RULE_06: second register low nibble arms 9-12 undervoltage
// RULE_07: second register high nibble arms 1-4 overvoltage
// RULE_08: third register bits 0-6 arm 5-11 overvoltage
// RULE_09: third register bit 7 arms 12 overvoltage
// RULE_10: armed fault kills enables, starts log transfer
// RULE_11: stored log locks logging until software unlocks
// RULE_12: fault flag sets only with matching enable
// RULE_13: enable bits map in regular channel order
// RULE_14: small variant ignores channels 9-12, unused bits
module cfl_trigger (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // register port
   input wire cfl_pkg::cfl_reg_req_t reg_req,
   output logic [cfl_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_hit,
   // monitor side
   input wire cfl_pkg::cfl_cmp_t cmp,
   input wire logic [cfl_pkg::NUM_CH*cfl_pkg::RES_W-1:0] conv_results,
   input wire logic small_variant,
   // fault flag read and clear
   input wire logic [cfl_pkg::NUM_CH-1:0] flag_clr,
   output logic [cfl_pkg::NUM_CH-1:0] fault_flags,
   // log writer side
   output logic log_req,
   output cfl_pkg::cfl_log_cmd_t log_cmd,
   input wire logic log_done,
   input wire logic log_unlock,
   output logic log_locked,
   output logic log_busy,
   // sequencer side
   output logic seq_shutdown
);

   //////////////////////////////////////////////////////////////////////////////////////////////////////
   // registers

   logic [cfl_pkg::CONTENT_W-1:0] content_r;
   logic [cfl_pkg::LOW_UV_W-1:0] uv_low_r;
   logic [cfl_pkg::DATA_W-1:0] mixed_r;
   logic [cfl_pkg::HIGH_OV_W-1:0] ov_high_r;

   logic wr_content;
   logic wr_low;
   logic wr_mixed;
   logic wr_high;

   // a write to any other address changes nothing
   assign wr_content = reg_req.wr && (reg_req.addr == cfl_pkg::ADDR_LOG_CONTENT);
   assign wr_low = reg_req.wr && (reg_req.addr == cfl_pkg::ADDR_UV_EN_LOW);
   assign wr_mixed = reg_req.wr && (reg_req.addr == cfl_pkg::ADDR_UVOV_EN_MIXED);
   assign wr_high = reg_req.wr && (reg_req.addr == cfl_pkg::ADDR_OV_EN_HIGH);

   // unused upper bits of the content register are never stored
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         content_r <= cfl_pkg::RST_LOG_CONTENT[cfl_pkg::CONTENT_W-1:0];
      end else if (wr_content) begin
         content_r <= reg_req.wdata[cfl_pkg::CONTENT_LSB +: cfl_pkg::CONTENT_W]; // RULE_14
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         uv_low_r <= cfl_pkg::RST_UV_EN_LOW;
      end else if (wr_low) begin
         uv_low_r <= reg_req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mixed_r <= cfl_pkg::RST_UVOV_EN_MIXED;
      end else if (wr_mixed) begin
         mixed_r <= reg_req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ov_high_r <= cfl_pkg::RST_OV_EN_HIGH;
      end else if (wr_high) begin
         ov_high_r <= reg_req.wdata;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////////
   // read back

   // read data registered; unmapped addresses read zero and drop reg_hit
   logic [cfl_pkg::DATA_W-1:0] rdata_nxt;
   logic hit_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt = 1'b1;
      unique case (reg_req.addr)
         cfl_pkg::ADDR_LOG_CONTENT: rdata_nxt = {6'h00, content_r};
         cfl_pkg::ADDR_UV_EN_LOW: rdata_nxt = uv_low_r;
         cfl_pkg::ADDR_UVOV_EN_MIXED: rdata_nxt = mixed_r;
         cfl_pkg::ADDR_OV_EN_HIGH: rdata_nxt = ov_high_r;
         default: hit_nxt = 1'b0;
      endcase
   end

   logic [cfl_pkg::DATA_W-1:0] rdata_r;
   logic hit_r;

   // read data stays put between reads so a slow reader can still pick it up
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
      end else if (reg_req.rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // the hit marker is a single-cycle pulse per read
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= reg_req.rd && hit_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_hit = hit_r;

   //////////////////////////////////////////////////////////////////////////////////////////////////////
   // per-channel enables in regular order

   logic [cfl_pkg::NUM_CH-1:0] uv_en;
   logic [cfl_pkg::NUM_CH-1:0] ov_en;
   logic [cfl_pkg::NUM_CH-1:0] present;
   logic [cfl_pkg::NUM_CH-1:0] armed_hit;

   // every enable bit arms its own channel in plain order, so no channel's UV or OV comparison is armed by two bits
   assign uv_en[cfl_pkg::LOW_UV_W-1:0] = uv_low_r; // RULE_05 RULE_13
   assign uv_en[11:8] = mixed_r[cfl_pkg::MIXED_UV_LSB +: cfl_pkg::MIXED_UV_W]; // RULE_06
   assign ov_en[3:0] = mixed_r[cfl_pkg::MIXED_OV_LSB +: cfl_pkg::MIXED_OV_W]; // RULE_07 RULE_13
   assign ov_en[10:4] = ov_high_r[cfl_pkg::HIGH_OV_LSB +: 7]; // RULE_08
   assign ov_en[11] = ov_high_r[7]; // RULE_09

   genvar g;
   generate
      for (g = 0; g < cfl_pkg::NUM_CH; g++) begin : g_ch
         // the small part has no inputs above its channel count
         assign present[g] = !small_variant || (g < cfl_pkg::SMALL_CH); // RULE_14
         cfl_chan_arm u_arm (
            .mclk(mclk),
            .nrst(nrst),
            .uv_en(uv_en[g]),
            .ov_en(ov_en[g]),
            .present(present[g]),
            .uv_hit(cmp.uv[g]),
            .ov_hit(cmp.ov[g]),
            .flag_clr(flag_clr[g]),
            .armed_hit(armed_hit[g]),
            .flag_r(fault_flags[g])
         );
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////////////////////////////
   // trigger, shutdown and lock

   typedef enum logic [1:0] {
      CFL_IDLE,
      CFL_REQ,
      CFL_WAIT
   } cfl_state_t;

   cfl_state_t state_r;
   cfl_pkg::cfl_content_t content_sel;
   logic fault_any;
   logic logger_on;
   logic log_start;
   logic store_done;
   logic shutdown_r;
   logic locked_r;

   assign content_sel = cfl_pkg::cfl_content_t'(content_r);
   assign fault_any = |armed_hit;
   assign logger_on = (content_sel != cfl_pkg::CFL_SAVE_NONE); // RULE_04
   // a fault while a log runs or is locked still shuts down, but starts no second log
   assign log_start = (state_r == CFL_IDLE) && fault_any && logger_on && !locked_r; // RULE_10 RULE_11
   assign store_done = (state_r == CFL_WAIT) && log_done;

   // shutdown holds from the first armed fault until reset; the sequencer restarts only after reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         shutdown_r <= 1'b0;
      end else if (fault_any) begin
         shutdown_r <= 1'b1; // RULE_10
      end
   end

   // lock: a finished store wins over an unlock in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         locked_r <= 1'b0;
      end else if (store_done) begin
         locked_r <= 1'b1; // RULE_11
      end else if (log_unlock) begin
         locked_r <= 1'b0; // RULE_11
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= CFL_IDLE;
      end else begin
         unique case (state_r)
            CFL_IDLE: if (log_start) state_r <= CFL_REQ; // RULE_10 RULE_11
            CFL_REQ: state_r <= CFL_WAIT;
            CFL_WAIT: if (log_done) state_r <= CFL_IDLE;
            // the fourth code is never entered; recover to idle should it appear
            default: state_r <= CFL_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////////
   // log command snapshot

   logic store_flags_r;
   logic store_values_r;
   logic [cfl_pkg::NUM_CH-1:0] snap_flags_r;
   logic [cfl_pkg::NUM_CH*cfl_pkg::RES_W-1:0] snap_values_r;

   // the selection is frozen as the log starts, so a later content write cannot alter a running log
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         store_flags_r <= 1'b0;
         store_values_r <= 1'b0;
      end else if (log_start) begin
         unique case (content_sel)
            cfl_pkg::CFL_SAVE_BOTH: begin
               store_flags_r <= 1'b1; // RULE_01
               store_values_r <= 1'b1; // RULE_01
            end
            cfl_pkg::CFL_SAVE_FLAGS: begin
               store_flags_r <= 1'b1; // RULE_02
               store_values_r <= 1'b0; // RULE_02
            end
            cfl_pkg::CFL_SAVE_VALUES: begin
               store_flags_r <= 1'b0; // RULE_03
               store_values_r <= 1'b1; // RULE_03
            end
            cfl_pkg::CFL_SAVE_NONE: begin
               store_flags_r <= 1'b0; // RULE_04
               store_values_r <= 1'b0; // RULE_04
            end
         endcase
      end
   end

   // flags and results are those of the cycle that armed the log
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         snap_flags_r <= '0;
      end else if (log_start) begin
         snap_flags_r <= armed_hit; // RULE_01 RULE_02
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         snap_values_r <= '0;
      end else if (log_start) begin
         snap_values_r <= conv_results; // RULE_01 RULE_03
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign log_cmd = {store_flags_r, store_values_r, snap_flags_r, snap_values_r};
   assign seq_shutdown = shutdown_r;
   assign log_locked = locked_r;
   assign log_req = (state_r == CFL_REQ); // RULE_10
   assign log_busy = (state_r != CFL_IDLE);

endmodule : cfl_trigger

`default_nettype wire

// file: tb/cfl_trigger_properties.sv
// cfl_trigger_properties: port-level timing checks for cfl_trigger
// assumes a bind onto cfl_trigger, one clock domain
`default_nettype none
module cfl_trigger_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // watched ports
   input wire cfl_pkg::cfl_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic [11:0] fault_flags,
   input wire logic log_req,
   input wire cfl_pkg::cfl_log_cmd_t log_cmd,
   input wire logic log_done,
   input wire logic log_locked,
   input wire logic log_busy,
   input wire logic seq_shutdown
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [1:0] mode_r;
   // shadow of the content field, rebuilt from writes since it is not a port
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) mode_r <= 2'h0;
      else if (reg_req.wr && reg_req.addr == 8'h47) mode_r <= reg_req.wdata[1:0];
   end
   sequence s_done; log_busy && log_done; endsequence
   sequence s_locked; ##1 (log_locked && !log_busy); endsequence
   a_req_one_cycle: assert property (log_req |=> !log_req) else $error("log request too long");
   a_req_shutdown: assert property (log_req |-> seq_shutdown && log_busy) else $error("request without stop");
   a_shut_sticky: assert property (seq_shutdown |=> seq_shutdown) else $error("shutdown dropped");
   a_content_kind: assert property (log_req |-> {log_cmd.store_flags, log_cmd.store_values} ==
      ($past(mode_r) == 2'h0 ? 2'h3 : $past(mode_r) == 2'h1 ? 2'h2 : 2'h1)) else $error("wrong log content");
   a_logger_off: assert property (mode_r == 2'h3 |=> !log_req) else $error("log while logger off");
   a_lock_no_req: assert property (log_locked |=> !log_req) else $error("log while locked");
   a_done_locks: assert property (s_done |-> s_locked) else $error("done did not lock");
   a_flag_shut: assert property ((fault_flags & ~$past(fault_flags)) != 12'h0 |-> seq_shutdown)
      else $error("flag without fault");
   a_unused_read: assert property (reg_req.rd && reg_req.addr == 8'h47 |=> reg_hit && reg_rdata[7:2] == 6'h0)
      else $error("unused content bits read back");
   a_unmapped_read: assert property (reg_req.rd && !(reg_req.addr inside {[8'h47:8'h4a]}) |=>
      !reg_hit && reg_rdata == 8'h00) else $error("unmapped read answered");
endmodule : cfl_trigger_properties
bind cfl_trigger cfl_trigger_properties chk_u (.mclk, .nrst, .reg_req, .reg_rdata, .reg_hit, .fault_flags,
   .log_req, .log_cmd, .log_done, .log_locked, .log_busy, .seq_shutdown);
`default_nettype wire

// file: tb/testbench.sv
// testbench: registers, channel mapping and log behaviour of cfl_trigger
// assumes the checker file is compiled with it and bound to the design
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   cfl_pkg::cfl_reg_req_t reg_req = '0;
   cfl_pkg::cfl_cmp_t cmp = '0;
   logic [95:0] conv = 96'h0123_4567_89ab_cdef_fedc_ba98;
   logic small_variant = 1'b0;
   logic [11:0] flag_clr = 12'h0;
   logic log_done = 1'b0;
   logic log_unlock = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_hit, log_req, log_locked, log_busy, seq_shutdown;
   logic [11:0] fault_flags;
   cfl_pkg::cfl_log_cmd_t log_cmd;
   int fail_count = 0;
   int num_checks = 0;
   always #12.5 mclk = ~mclk;
   cfl_trigger dut_u (.mclk, .nrst, .reg_req, .reg_rdata, .reg_hit, .cmp, .conv_results(conv), .small_variant,
      .flag_clr, .fault_flags, .log_req, .log_cmd, .log_done, .log_unlock, .log_locked, .log_busy, .seq_shutdown);
   ////////////////////////////////////////
   task automatic tick();
      @(posedge mclk);
      #2;
   endtask : tick
   task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask : chk
   // an idle cycle after each access keeps drivers from assigning twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      tick();
      reg_req = '0;
      tick();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick();
      reg_req = '0;
      chk(reg_rdata, exp, "read data");
      chk(reg_hit, hit, "read hit");
      tick();
   endtask : rd
   task automatic reg_test();
      for (int i = 0; i < 4; i++) rd(8'h47 + 8'(i), 8'h00, 1'b1);
      wr(8'h47, 8'hff);
      rd(8'h47, 8'h03, 1'b1);
      for (int i = 1; i < 4; i++) begin
         wr(8'h47 + 8'(i), 8'ha5 ^ 8'(i));
         rd(8'h47 + 8'(i), 8'ha5 ^ 8'(i), 1'b1);
      end
      wr(8'h4b, 8'hff);
      rd(8'h4b, 8'h00, 1'b0);
      $display("reg_test done");
   endtask : reg_test
   task automatic map_test();
      logic [23:0] en;
      logic [11:0] one;
      wr(8'h47, 8'h03);
      for (int p = 0; p < 24; p++) begin
         en = 24'h1 << p;
         one = 12'h1 << (p % 12);
         for (int r = 0; r < 3; r++) wr(8'h48 + 8'(r), en[8*r +: 8]);
         cmp = (p < 12) ? {~one, 12'hfff} : {12'hfff, ~one};
         tick();
         chk(fault_flags, 12'h0, "unarmed flags");
         chk(seq_shutdown, p != 0, "early shutdown");
         cmp = (p < 12) ? {one, 12'h0} : {12'h0, one};
         tick();
         cmp = '0;
         chk(fault_flags, one, "armed flag");
         chk(seq_shutdown, 1'b1, "shutdown on fault");
         flag_clr = one;
         tick();
         flag_clr = 12'h0;
         chk(fault_flags, 12'h0, "flag clear");
      end
      small_variant = 1'b1;
      wr(8'h49, 8'h01);
      cmp = {12'h100, 12'h0};
      tick();
      cmp = '0;
      chk(fault_flags, 12'h0, "small part ch9");
      small_variant = 1'b0;
      $display("map_test done");
   endtask : map_test
   task automatic log_test();
      logic [1:0] c;
      wr(8'h49, 8'h00);
      wr(8'h4a, 8'h00);
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         wr(8'h47, {6'h0, c});
         wr(8'h48, 8'h01);
         cmp = {12'h1, 12'h0};
         tick();
         cmp = '0;
         chk(seq_shutdown, 1'b1, "shutdown");
         chk(log_req, c != 2'h3, "log request");
         chk(log_busy, c != 2'h3, "busy");
         if (c != 2'h3) begin
            chk({log_cmd.store_flags, log_cmd.store_values}, c == 2'h0 ? 2'h3 : c == 2'h1 ? 2'h2 : 2'h1, "kind");
            chk(log_cmd.fail_flags, 12'h1, "logged flags");
            chk(log_cmd.values, conv, "logged values");
         end
         tick();
         chk(log_req, 1'b0, "request width");
         log_done = (c != 2'h3);
         tick();
         log_done = 1'b0;
         chk(log_locked, c != 2'h3, "lock");
         flag_clr = 12'hfff;
         tick();
         flag_clr = 12'h0;
         cmp = {12'h1, 12'h0};
         tick();
         cmp = '0;
         chk(log_req, 1'b0, "second log");
         log_unlock = 1'b1;
         tick();
         log_unlock = 1'b0;
         chk(log_locked, 1'b0, "unlock");
      end
      $display("log_test done");
   endtask : log_test
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (12) @(posedge mclk);
      #2;
      nrst = 1'b1;
      tick();
      reg_test();
      map_test();
      log_test();
      give_verdict();
   end
   // the tests need under 1000 cycles
   initial begin
      repeat (4000) @(posedge mclk);
      fail_count++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
